// ===== mcsc_main_clock_ctrl.sv
// Main clock source selection, oscillator enables and CPU divider
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1 - Oscillator pins stay port mode after reset
// RL2 - Select 0/1 gives crystal oscillation mode
// RL3 - Select 1/1 gives external clock mode
// RL4 - Halt cleared starts crystal oscillator
// RL5 - Halt cleared accepts external clock input
// RL6 - Software polls settle status before use
// RL7 - Software keeps pin selects while running
// RL8 - Both selects high: high-speed main, peripheral
// RL9 - High-speed main forces high-speed peripheral clock
// RL10 - Source select low: internal main, peripheral
// RL11 - Divider codes 0-4, default divide two
// RL12 - Flags report current CPU clock source
// RL13 - Stop mode halts high-speed source
// RL14 - Halt set stops high-speed source
// RL15 - Software checks flags before halting
// RL16 - Software sets wake settle time first
// RL17 - Software stops unsupported peripherals first
// RL18 - Internal halt cleared restarts oscillator
// RL19 - Stable flag set when accuracy reached
// RL20 - Internal oscillator runs, selected after reset
// RL21 - Internal halt set stops oscillator
// RL22 - Sub select gives subsystem clock halved
// RL23 - Stable flag cleared while stopped
module mcsc_main_clock_ctrl
    import mcsc_pkg::*;
#(
    parameter logic [11:0] INT_SETTLE_CYC = 12'(MCSC_INT_SETTLE_CYC)
) (
    input  wire logic       CLOCK,
    input  wire logic       RST,
    input  wire logic       EXT_CLOCK_SELECT,
    input  wire logic       HS_PIN_OSC_SELECT,
    input  wire logic       HS_OSC_HALT,
    input  wire logic       HS_SOURCE_SELECT,
    input  wire logic       MAIN_CLOCK_MUX_BIT,
    input  wire logic       CPU_SUB_SELECT,
    input  wire logic [2:0] CPU_DIV_CODE,
    input  wire logic       CPU_DIV_WRITE,
    input  wire logic       INT_HS_OSC_HALT,
    input  wire logic       STOP_EXEC,
    input  wire logic       WAKE,
    output logic [1:0]      PIN_MODE,
    output logic            XTAL_OSC_ENABLE,
    output logic            EXT_CLK_INPUT_ENABLE,
    output logic            INT_OSC_ENABLE,
    output logic            MAIN_IS_HS,
    output logic            PERIPH_IS_HS,
    output logic [2:0]      CPU_DIV_SEL,
    output logic            CPU_USE_SUB_HALF,
    output logic            CPU_ON_SUB_FLAG,
    output logic            CPU_MAIN_SRC_FLAG,
    output logic            INT_HS_OSC_STABLE_FLAG,
    output logic            STOP_MODE
);
    mcsc_pin_mode_e pin_mode_d;
    logic           stop_q;
    logic [2:0]     div_q;
    logic           int_run;
    logic           hs_run_d;

    // Pin mode decode; port mode unless OSC select is set
    always_comb begin
        pin_mode_d = MCSC_PIN_PORT; // RL1
        if (HS_PIN_OSC_SELECT && !EXT_CLOCK_SELECT) begin
            pin_mode_d = MCSC_PIN_XTAL; // RL2
        end else if (HS_PIN_OSC_SELECT && EXT_CLOCK_SELECT) begin
            pin_mode_d = MCSC_PIN_EXTCK; // RL3
        end
    end

    // Stop mode held until a wake event arrives
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            stop_q <= 1'b0;
        end else if (WAKE) begin
            stop_q <= 1'b0;
        end else if (STOP_EXEC) begin
            stop_q <= 1'b1; // RL13
        end
    end

    // Prohibited divider codes are ignored, keeping the last legal one
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            div_q <= MCSC_DIV_RST; // RL11
        end else if (CPU_DIV_WRITE && CPU_DIV_CODE <= MCSC_DIV_MAX) begin
            div_q <= CPU_DIV_CODE; // RL11
        end
    end

    assign hs_run_d = !HS_OSC_HALT && !stop_q; // RL4 RL5 RL14 RL13
    assign int_run  = !INT_HS_OSC_HALT && !stop_q; // RL18 RL21 RL20

    // Registered source enables and pin mode
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PIN_MODE             <= MCSC_PIN_PORT; // RL1
            XTAL_OSC_ENABLE      <= 1'b0;
            EXT_CLK_INPUT_ENABLE <= 1'b0;
            INT_OSC_ENABLE       <= 1'b1; // RL20
        end else begin
            PIN_MODE             <= pin_mode_d;
            XTAL_OSC_ENABLE      <= hs_run_d
                && pin_mode_d == MCSC_PIN_XTAL; // RL4 RL14
            EXT_CLK_INPUT_ENABLE <= hs_run_d
                && pin_mode_d == MCSC_PIN_EXTCK; // RL5 RL14
            INT_OSC_ENABLE       <= int_run; // RL18 RL21
        end
    end

    // Clock routing; the peripheral clock follows the main when it is HS
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            MAIN_IS_HS        <= 1'b0; // RL20
            PERIPH_IS_HS      <= 1'b0;
            CPU_DIV_SEL       <= MCSC_DIV_RST;
            CPU_USE_SUB_HALF  <= 1'b0;
            CPU_ON_SUB_FLAG   <= 1'b0;
            CPU_MAIN_SRC_FLAG <= 1'b0;
        end else begin
            MAIN_IS_HS        <= HS_SOURCE_SELECT
                && MAIN_CLOCK_MUX_BIT; // RL8 RL10
            PERIPH_IS_HS      <= HS_SOURCE_SELECT; // RL8 RL9 RL10
            CPU_DIV_SEL       <= div_q; // RL11
            CPU_USE_SUB_HALF  <= CPU_SUB_SELECT; // RL22
            CPU_ON_SUB_FLAG   <= CPU_SUB_SELECT; // RL12
            CPU_MAIN_SRC_FLAG <= HS_SOURCE_SELECT
                && MAIN_CLOCK_MUX_BIT; // RL12
        end
    end

    // Accuracy timer for the internal oscillator
    mcsc_settle_timer #(
        .CNT_W  (MCSC_CNT_W),
        .CYCLES (INT_SETTLE_CYC)
    ) u_int_settle (
        .CLOCK  (CLOCK),
        .RST    (RST),
        .run    (int_run),
        .stable (INT_HS_OSC_STABLE_FLAG) // RL19 RL23
    );

    assign STOP_MODE = stop_q;

    // Checks one edge behind the inputs, two for stop mode and the stable flag rise, matching the registered outputs
    a_pin_xtal_mode: assert property (@(posedge CLOCK) disable iff (RST)
        HS_PIN_OSC_SELECT && !EXT_CLOCK_SELECT
        |=> PIN_MODE == MCSC_PIN_XTAL) // RL2
        else $error("crystal pin mode not entered");
    a_pin_ext_mode: assert property (@(posedge CLOCK) disable iff (RST)
        HS_PIN_OSC_SELECT && EXT_CLOCK_SELECT
        |=> PIN_MODE == MCSC_PIN_EXTCK) // RL3
        else $error("external clock mode not entered");
    a_pin_port_mode: assert property (@(posedge CLOCK) disable iff (RST)
        !HS_PIN_OSC_SELECT |=> PIN_MODE == MCSC_PIN_PORT) // RL1
        else $error("pins left port mode");
    a_xtal_start: assert property (@(posedge CLOCK) disable iff (RST)
        !HS_OSC_HALT && !stop_q && HS_PIN_OSC_SELECT && !EXT_CLOCK_SELECT
        |=> XTAL_OSC_ENABLE) // RL4
        else $error("crystal not started");
    a_hs_halt_stop: assert property (@(posedge CLOCK) disable iff (RST)
        HS_OSC_HALT |=> !XTAL_OSC_ENABLE && !EXT_CLK_INPUT_ENABLE) // RL14
        else $error("high-speed source not stopped");
    a_stop_mode_halt: assert property (@(posedge CLOCK) disable iff (RST)
        STOP_EXEC && !WAKE |=> ##1 !XTAL_OSC_ENABLE
        && !EXT_CLK_INPUT_ENABLE) // RL13
        else $error("stop mode left high-speed running");
    a_periph_follows: assert property (@(posedge CLOCK) disable iff (RST)
        MAIN_IS_HS |-> PERIPH_IS_HS) // RL9
        else $error("peripheral clock not high-speed");
    a_main_select: assert property (@(posedge CLOCK) disable iff (RST)
        HS_SOURCE_SELECT && MAIN_CLOCK_MUX_BIT
        |=> MAIN_IS_HS && CPU_MAIN_SRC_FLAG) // RL8
        else $error("main clock not high-speed");
    a_int_source: assert property (@(posedge CLOCK) disable iff (RST)
        !HS_SOURCE_SELECT |=> !MAIN_IS_HS && !PERIPH_IS_HS) // RL10
        else $error("internal clock not selected");
    a_div_legal: assert property (@(posedge CLOCK) disable iff (RST)
        CPU_DIV_WRITE && CPU_DIV_CODE > MCSC_DIV_MAX
        |=> $stable(div_q)) // RL11
        else $error("prohibited divider code taken");
    a_sub_flag: assert property (@(posedge CLOCK) disable iff (RST)
        CPU_SUB_SELECT |=> CPU_ON_SUB_FLAG && CPU_USE_SUB_HALF) // RL12
        else $error("subsystem flag wrong");
    a_int_restart: assert property (@(posedge CLOCK) disable iff (RST)
        !INT_HS_OSC_HALT && !stop_q |=> INT_OSC_ENABLE) // RL18
        else $error("internal oscillator not running");
    a_stable_clear: assert property (@(posedge CLOCK) disable iff (RST)
        !int_run |=> !INT_HS_OSC_STABLE_FLAG) // RL23
        else $error("stable flag kept while stopped");
    a_stable_rise: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(INT_HS_OSC_STABLE_FLAG) |-> $past(int_run, 2)) // RL19
        else $error("stable flag rose without run");
    a_ext_start: assert property (@(posedge CLOCK) disable iff (RST)
        !HS_OSC_HALT && !stop_q && HS_PIN_OSC_SELECT && EXT_CLOCK_SELECT
        |=> EXT_CLK_INPUT_ENABLE) // RL5
        else $error("external clock input not enabled");
    a_int_halt_stop: assert property (@(posedge CLOCK) disable iff (RST)
        INT_HS_OSC_HALT |=> !INT_OSC_ENABLE) // RL21
        else $error("internal oscillator not stopped");
    a_periph_only_hs: assert property (@(posedge CLOCK) disable iff (RST)
        HS_SOURCE_SELECT && !MAIN_CLOCK_MUX_BIT
        |=> !MAIN_IS_HS && PERIPH_IS_HS) // RL10
        else $error("peripheral-only high-speed routing wrong");
    a_div_take: assert property (@(posedge CLOCK) disable iff (RST)
        CPU_DIV_WRITE && CPU_DIV_CODE <= MCSC_DIV_MAX
        |=> div_q == $past(CPU_DIV_CODE)) // RL11
        else $error("legal divider code not taken");

    // Main scenarios the bench is expected to reach
    c_periph_only: cover property (@(posedge CLOCK) disable iff (RST)
        PERIPH_IS_HS && !MAIN_IS_HS);
    c_xtal_run: cover property (@(posedge CLOCK) disable iff (RST)
        $rose(XTAL_OSC_ENABLE));
    c_ext_run: cover property (@(posedge CLOCK) disable iff (RST)
        $rose(EXT_CLK_INPUT_ENABLE));
    c_stable: cover property (@(posedge CLOCK) disable iff (RST)
        $rose(INT_HS_OSC_STABLE_FLAG));
    c_stop: cover property (@(posedge CLOCK) disable iff (RST)
        $rose(STOP_MODE));
endmodule : mcsc_main_clock_ctrl
`default_nettype wire

// ===== mcsc_main_clock_ctrl_test.sv
// Self-checking bench for the main clock source control block
`timescale 1ns/1ps
`default_nettype none
module mcsc_main_clock_ctrl_test
    import mcsc_pkg::*;
;
    localparam logic [11:0] SETTLE = 12'h004;
    logic       clock, rst, ext_sel, pin_sel, hs_halt, src_sel, mux_bit;
    logic       sub_sel, div_wr, int_halt, stop_exec, wake, hs_clk;
    logic       xtal_en, ext_en, int_en, main_hs, per_hs, use_sub, on_sub;
    logic       main_src, stable, stop_mode;
    logic [1:0] pin_mode;
    logic [2:0] div_code, div_sel, exp_div;
    int         n_mismatch, n_tests;

    mcsc_main_clock_ctrl #(.INT_SETTLE_CYC(SETTLE)) i_mcsc_main_clock_ctrl (
        .CLOCK(clock), .RST(rst), .EXT_CLOCK_SELECT(ext_sel),
        .HS_PIN_OSC_SELECT(pin_sel), .HS_OSC_HALT(hs_halt),
        .HS_SOURCE_SELECT(src_sel), .MAIN_CLOCK_MUX_BIT(mux_bit),
        .CPU_SUB_SELECT(sub_sel), .CPU_DIV_CODE(div_code),
        .CPU_DIV_WRITE(div_wr), .INT_HS_OSC_HALT(int_halt),
        .STOP_EXEC(stop_exec), .WAKE(wake), .PIN_MODE(pin_mode),
        .XTAL_OSC_ENABLE(xtal_en), .EXT_CLK_INPUT_ENABLE(ext_en),
        .INT_OSC_ENABLE(int_en), .MAIN_IS_HS(main_hs), .PERIPH_IS_HS(per_hs),
        .CPU_DIV_SEL(div_sel), .CPU_USE_SUB_HALF(use_sub),
        .CPU_ON_SUB_FLAG(on_sub), .CPU_MAIN_SRC_FLAG(main_src),
        .INT_HS_OSC_STABLE_FLAG(stable), .STOP_MODE(stop_mode));

    mcsc_xtal_model i_mcsc_xtal_model (
        .xtal_en(xtal_en), .ext_en(ext_en), .hs_clk(hs_clk));

    // Free-running system clock
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    task automatic check(input logic [2:0] got, input logic [2:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t: got %b expected %b", $time, got, exp);
        end
    endtask : check

    // Inputs move only on falling edges, clear of the sampling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    task automatic set_div(input logic [2:0] code);
        div_code = code;
        div_wr = 1'h1;
        cyc(1);
        div_wr = 1'h0;
        cyc(3);
    endtask : set_div

    task automatic report_and_stop;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        {rst, hs_halt} = 2'h3;
        {ext_sel, pin_sel, src_sel, mux_bit, sub_sel} = 5'h00;
        {div_wr, int_halt, stop_exec, wake} = 4'h0;
        div_code = 3'h0;
        exp_div = 3'h1;
        n_mismatch = 0;
        n_tests = 0;
        // Count rising edges so a time-zero clock event cannot shorten reset
        repeat (3) @(posedge clock);
        cyc(1);
        rst = 1'h0;
        check(pin_mode, 3'h0);
        check(int_en, 3'h1);
        check(div_sel, 3'h1);
        check({on_sub, main_src}, 3'h0);
        cyc(SETTLE + 4);
        check(stable, 3'h1);
        // Crystal mode, then every source select combination
        pin_sel = 1'h1;
        hs_halt = 1'h0;
        cyc(3);
        check(pin_mode, 3'h1);
        check({ext_en, xtal_en}, 3'h1);
        for (int i = 0; i < 4; i++) begin
            {src_sel, mux_bit} = i[1:0];
            cyc(3);
            check({main_hs, per_hs}, {src_sel & mux_bit, src_sel});
            check(main_src, src_sel & mux_bit);
        end
        src_sel = 1'h0;
        cyc(3);
        hs_halt = 1'h1;
        cyc(3);
        check(xtal_en, 3'h0);
        check(hs_clk, 3'h0);
        // Pin mode changed only while halted
        ext_sel = 1'h1;
        cyc(3);
        check(pin_mode, 3'h2);
        hs_halt = 1'h0;
        cyc(3);
        check({ext_en, xtal_en}, 3'h2);
        // Stop instruction, then wake; CPU is on the internal clock here,
        // so no wake settle time is programmed and no peripheral is running
        stop_exec = 1'h1;
        cyc(1);
        stop_exec = 1'h0;
        cyc(2);
        check({stop_mode, ext_en, int_en}, 3'h4);
        check(stable, 3'h0);
        wake = 1'h1;
        cyc(1);
        wake = 1'h0;
        cyc(SETTLE + 4);
        check({stop_mode, ext_en, int_en}, 3'h3);
        check(stable, 3'h1);
        hs_halt = 1'h1;
        cyc(3);
        check(ext_en, 3'h0);
        check(hs_clk, 3'h0);
        // All divider codes; prohibited ones must leave the ratio alone
        for (int c = 0; c < 8; c++) begin
            set_div(c[2:0]);
            exp_div = (c <= 4) ? c[2:0] : exp_div;
            check(div_sel, exp_div);
        end
        sub_sel = 1'h1;
        cyc(3);
        check({use_sub, on_sub}, 3'h3);
        // Internal oscillator halt and restart
        int_halt = 1'h1;
        cyc(3);
        check({int_en, stable}, 3'h0);
        int_halt = 1'h0;
        cyc(1);
        check(stable, 3'h0);
        cyc(SETTLE + 4);
        check({int_en, stable}, 3'h3);
        report_and_stop();
    end
endmodule : mcsc_main_clock_ctrl_test
`default_nettype wire

// ===== mcsc_pkg.sv
// Package of constants for the main clock source control block
`default_nettype none
package mcsc_pkg;
    // Pin operation modes of the high-speed oscillator pins
    typedef enum logic [1:0] {
        MCSC_PIN_PORT  = 2'b00,
        MCSC_PIN_XTAL  = 2'b01,
        MCSC_PIN_EXTCK = 2'b10
    } mcsc_pin_mode_e;

    // Reset values of control bits and the largest legal divider code
    localparam logic [2:0] MCSC_DIV_RST      = 3'h1;
    localparam logic [2:0] MCSC_DIV_MAX      = 3'h4;
    localparam logic       MCSC_HS_HALT_RST  = 1'b1;
    localparam logic       MCSC_INT_HALT_RST = 1'b0;

    // Internal oscillator accuracy settling time
    localparam int MCSC_CLK_MHZ         = 125;
    localparam int MCSC_INT_SETTLE_NS   = 2000;
    localparam int MCSC_INT_SETTLE_CYC  =
        (MCSC_INT_SETTLE_NS * MCSC_CLK_MHZ + 999) / 1000;
    localparam int MCSC_CNT_W           = 12;
endpackage : mcsc_pkg
`default_nettype wire

// ===== mcsc_settle_timer.sv
// Settling counter that flags an oscillator as accurate after a delay
`timescale 1ns/1ps
`default_nettype none
module mcsc_settle_timer #(
    parameter int          CNT_W  = 12,
    parameter logic [11:0] CYCLES = 12'h0fa
) (
    input  wire logic CLOCK,
    input  wire logic RST,
    input  wire logic run,
    output logic      stable
);
    logic [CNT_W-1:0] cnt_q;

    // Counter clears whenever the source stops, so restart waits anew
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (cnt_q != CNT_W'(CYCLES)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Flag registered so it never glitches on a halt
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            stable <= 1'b0;
        end else begin
            stable <= run && (cnt_q == CNT_W'(CYCLES));
        end
    end
endmodule : mcsc_settle_timer
`default_nettype wire

// ===== mcsc_xtal_model.sv
// Behavioural crystal or external clock source on the oscillator pins
`timescale 1ns/1ps
`default_nettype none
module mcsc_xtal_model (
    input  wire logic xtal_en,
    input  wire logic ext_en,
    output logic      hs_clk
);
    // Source toggles only while enabled, and stands still at low otherwise.
    // The bench must not rely on this clock before its settle wait ends.
    initial begin
        hs_clk = 1'h0;
        forever begin
            #5;
            hs_clk = (xtal_en | ext_en) ? ~hs_clk : 1'h0;
        end
    end
endmodule : mcsc_xtal_model
`default_nettype wire
